// file: core/iolvl_core.sv
// Active-level selection for system inputs, general inputs and system outputs
module iolvl_core
   import iolvl_pkg::*;
(
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst_b,
   // Pins from switches, sensors and driver
   input  wire logic [N_SYS_PIN-1:0]     io_in_pin,
   input  wire logic [N_SYS_PIN-1:0]     drv_in_pin,
   input  wire logic [N_GEN-1:0]         general_input,
   // Connector and general input configuration
   input  wire logic                     drv_conn_en,
   input  wire logic [N_GEN-1:0]         gen_assign_en,
   input  wire logic [N_GEN-1:0][FN_W-1:0] gen_assign_fn,
   // Level setting access
   input  wire logic                     lv_wr_en,
   input  wire logic [IDX_W-1:0]         lv_wr_idx,
   input  wire logic                     lv_wr_val,
   input  wire logic [IDX_W-1:0]         lv_rd_idx,
   output logic                          lv_rd_val,
   input  wire logic                     save_parameters_cmd,
   // Nonvolatile storage
   input  wire logic [LV_N-1:0]          nvm_level,
   input  wire logic [LV_N-1:0]          nvm_valid,
   output logic                          nvm_save_stb,
   output logic [LV_N-1:0]               nvm_save_data,
   // Internal asserted outputs from the motion logic
   input  wire logic [N_OUT-1:0]         sys_out_assert,
   // Sensed results and driven pins
   output logic [N_SYS_PIN-1:0]          sys_in_active,
   output logic [N_GEN-1:0]              gen_in_status,
   output logic [N_OUT-1:0]              io_out_pin,
   output logic [N_OUT-1:0]              drv_out_pin,
   output logic [LV_N-1:0]               active_level_setting
);

   iolvl_state_t    st;        // Registered state
   iolvl_state_t    next_st;   // Next state
   logic [LV_N-1:0] load_val;  // Levels taken at power up

   // ****************************************************************
   // Power-up load value
   // ****************************************************************
   // Saved levels where storage holds one, factory level elsewhere
   always_comb begin
      load_val = (nvm_level & nvm_valid) | (LV_DEFAULT & ~nvm_valid);
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic lvl;
      lvl = 1'b0;
      next_st = st;
      // Two-flop synchronisers, stage 1 read only by stage 2
      next_st.io_s1  = io_in_pin;
      next_st.io_s2  = st.io_s1;
      next_st.drv_s1 = drv_in_pin;
      next_st.drv_s2 = st.drv_s1;
      next_st.gen_s1 = general_input;
      next_st.gen_s2 = st.gen_s1;
      // Save hands the written levels to storage; nothing in force changes
      next_st.save_stb  = save_parameters_cmd;
      next_st.save_data = st.written;
      if (!st.loaded) begin
         // First edge after reset: unsaved writes are gone
         next_st.active  = load_val;
         next_st.written = load_val;
         next_st.loaded  = 1'b1;
      end else if (lv_wr_en && (int'(lv_wr_idx) < LV_N)) begin
         // Writes touch only the shadow copy until save and reset
         next_st.written[lv_wr_idx] = lv_wr_val;
      end
      // System inputs: XOR with the level gives NO/NC or pos/neg logic
      for (int p = 0; p < N_SYS_PIN; p++) begin
         lvl = st.active[pin_lv(p)];
         next_st.sys_in_active[p] = (st.io_s2[p] ^ lvl)
                                  | (drv_conn_en & (st.drv_s2[p] ^ lvl));
      end
      // General inputs: an assigned function's level overrides its own
      for (int g = 0; g < N_GEN; g++) begin
         if (gen_assign_en[g] && (int'(gen_assign_fn[g]) < N_SYS_LV)) begin
            lvl = st.active[gen_assign_fn[g]];
         end else begin
            lvl = st.active[LV_GEN_BASE + g];
         end
         next_st.gen_in_status[g] = st.gen_s2[g] ^ lvl;
      end
      // Outputs: inverted when normally closed; driver copy only when in use
      for (int k = 0; k < N_OUT; k++) begin
         next_st.io_out_pin[k]  = sys_out_assert[k] ^ st.active[LV_OUT_BASE + k];
         next_st.drv_out_pin[k] = drv_conn_en
                                & (sys_out_assert[k] ^ st.active[LV_OUT_BASE + k]);
      end
      // Readback of the written copy, zero beyond the table
      if (int'(lv_rd_idx) < LV_N) begin
         next_st.lv_rd_val = st.written[lv_rd_idx];
      end else begin
         next_st.lv_rd_val = 1'b0;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Factory levels stand until the load edge, so sensing is sane at once
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st         <= '0;
         st.active  <= LV_DEFAULT;
         st.written <= LV_DEFAULT;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign lv_rd_val            = st.lv_rd_val;
   assign nvm_save_stb         = st.save_stb;
   assign nvm_save_data        = st.save_data;
   assign sys_in_active        = st.sys_in_active;
   assign gen_in_status        = st.gen_in_status;
   assign io_out_pin           = st.io_out_pin;
   assign drv_out_pin          = st.drv_out_pin;
   assign active_level_setting = st.active;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Before the load edge the factory levels are in force
   property p_factory_default;
      @(posedge ref_clk) disable iff (!rst_b)
      !st.loaded |-> st.active == LV_DEFAULT;
   endproperty
   a_factory_default: assert property (p_factory_default) else $error("factory level wrong");

   // Once loaded, levels in force never move, whatever is written
   property p_frozen;
      @(posedge ref_clk) disable iff (!rst_b)
      st.loaded |=> $stable(st.active);
   endproperty
   a_frozen: assert property (p_frozen) else $error("active level changed without reset");

   // Saved value taken at the load edge
   property p_load_saved;
      @(posedge ref_clk) disable iff (!rst_b)
      (!st.loaded && nvm_valid[LV_ABORT]) |=> st.active[LV_ABORT] == $past(nvm_level[LV_ABORT]);
   endproperty
   a_load_saved: assert property (p_load_saved) else $error("saved level not loaded");

   // Never saved: factory value, one for the timing input
   property p_load_default;
      @(posedge ref_clk) disable iff (!rst_b)
      (!st.loaded && !nvm_valid[LV_TIMING_DIFF]) |=> st.active[LV_TIMING_DIFF];
   endproperty
   a_load_default: assert property (p_load_default) else $error("default level not loaded");

   // Abort pin sensed three edges later through its own level
   // The connector enable that counts is the one sampled one edge before the check
   sequence s_abort_settled;
      st.loaded ##2 !drv_conn_en ##1 1'b1;
   endsequence
   property p_abort_sense;
      @(posedge ref_clk) disable iff (!rst_b)
      s_abort_settled |-> sys_in_active[LV_ABORT]
                          == ($past(io_in_pin[LV_ABORT], 3) ^ st.active[LV_ABORT]);
   endproperty
   a_abort_sense: assert property (p_abort_sense) else $error("abort sense wrong");

   // Negative limit follows the overtravel level
   property p_neg_limit;
      @(posedge ref_clk) disable iff (!rst_b)
      (st.loaded && !drv_conn_en) |=> sys_in_active[PIN_NEG_LIMIT]
                                      == ($past(st.io_s2[PIN_NEG_LIMIT]) ^ st.active[LV_OVERTRAVEL]);
   endproperty
   a_neg_limit: assert property (p_neg_limit) else $error("negative limit sense wrong");

   // Zero-phase input uses positive or negative logic
   property p_ext_zero;
      @(posedge ref_clk) disable iff (!rst_b)
      (st.loaded && !drv_conn_en) |=> sys_in_active[LV_EXT_ZERO]
                                      == ($past(st.io_s2[LV_EXT_ZERO]) ^ st.active[LV_EXT_ZERO]);
   endproperty
   a_ext_zero: assert property (p_ext_zero) else $error("zero-phase sense wrong");

   // Assigned general input uses its function's level
   property p_gen_assigned;
      @(posedge ref_clk) disable iff (!rst_b)
      (st.loaded && gen_assign_en[0] && gen_assign_fn[0] == FN_W'(LV_ABORT))
      |=> gen_in_status[0] == ($past(st.gen_s2[0]) ^ st.active[LV_ABORT]);
   endproperty
   a_gen_assigned: assert property (p_gen_assigned) else $error("assigned input level wrong");

   // Unassigned general input uses its own level
   property p_gen_own;
      @(posedge ref_clk) disable iff (!rst_b)
      (st.loaded && !gen_assign_en[8])
      |=> gen_in_status[8] == ($past(st.gen_s2[8]) ^ st.active[LV_GEN_BASE + 8]);
   endproperty
   a_gen_own: assert property (p_gen_own) else $error("general input level wrong");

   // Output 0 on both connectors follows the asserted state and level
   property p_out_level;
      @(posedge ref_clk) disable iff (!rst_b)
      (st.loaded && drv_conn_en) |=> (io_out_pin[0] == ($past(sys_out_assert[0]) ^ st.active[LV_OUT_BASE]))
                                     && (drv_out_pin[0] == io_out_pin[0]);
   endproperty
   a_out_level: assert property (p_out_level) else $error("output level wrong");

   // Driver copy of the pause input is ORed in while that connector is in use
   property p_drv_sense;
      @(posedge ref_clk) disable iff (!rst_b)
      (st.loaded && drv_conn_en) |=> sys_in_active[LV_PAUSE]
                                     == (($past(st.io_s2[LV_PAUSE]) ^ st.active[LV_PAUSE])
                                         | ($past(st.drv_s2[LV_PAUSE]) ^ st.active[LV_PAUSE]));
   endproperty
   a_drv_sense: assert property (p_drv_sense) else $error("driver connector sense wrong");

   // A write lands in the shadow copy only; the levels in force wait for reset
   property p_wr_shadow;
      @(posedge ref_clk) disable iff (!rst_b)
      (st.loaded && lv_wr_en && lv_wr_idx == IDX_W'(LV_ABORT))
      |=> st.written[LV_ABORT] == $past(lv_wr_val);
   endproperty
   a_wr_shadow: assert property (p_wr_shadow) else $error("written level not kept");

   // Save hands the written copy to storage one cycle later
   property p_save;
      @(posedge ref_clk) disable iff (!rst_b)
      save_parameters_cmd |=> nvm_save_stb && (nvm_save_data == $past(st.written));
   endproperty
   a_save: assert property (p_save) else $error("save not handed to storage");

endmodule

// file: core/iolvl_pkg.sv
// Package with indices, defaults and the state record of the active-level block
// Notes on behaviour
// - Level 0 normally open, 1 normally closed
// - Zero-phase and timing inputs: 0 positive, 1 negative
// - All defaults 0, timing input defaults 1
// - Written level waits for save and reset
// - Power up loads last saved level
// - Never saved: load factory default instead
// - Level applies on both connectors
// - Assigned general input uses system function level
// - Nine general inputs, each own level
// - One overtravel level for both limits
// - Abort input has own level
// - Each home-seek input has own level
package iolvl_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int LV_N      = 38;    // All level settings
   localparam int N_SYS_LV  = 21;    // System input settings
   localparam int N_GEN     = 9;     // General inputs
   localparam int N_OUT     = 8;     // System outputs
   localparam int N_SYS_PIN = 22;    // System input pins (two limits share one level)
   localparam int IDX_W     = 6;     // Width of a setting index
   localparam int FN_W      = 5;     // Width of a system function code

   // ****************************************************************
   // Setting indices (system inputs equal their pin index)
   // ****************************************************************
   localparam int LV_ABORT         = 0;
   localparam int LV_ALARM_CLEAR   = 1;
   localparam int LV_CURRENT_ON    = 2;
   localparam int LV_CONTINUE      = 3;
   localparam int LV_EXT_ZERO      = 4;
   localparam int LV_FREE          = 5;
   localparam int LV_HOME_SENSOR   = 6;
   localparam int LV_RUN_POS       = 7;
   localparam int LV_RUN_NEG       = 8;
   localparam int LV_HOME_SEEK_POS = 9;
   localparam int LV_HOME_SEEK_NEG = 10;
   localparam int LV_MOTOR_STOP    = 11;
   localparam int LV_OVERTRAVEL    = 12;   // Also the positive limit pin
   localparam int LV_PAUSE_CLEAR   = 13;
   localparam int LV_PAUSE         = 14;
   localparam int LV_POS_ERR_CLEAR = 15;
   localparam int LV_PANIC_STOP    = 16;
   localparam int LV_SENSOR        = 17;
   localparam int LV_START         = 18;
   localparam int LV_TIMING_DIFF   = 19;
   localparam int LV_TORQUE_LIMIT  = 20;
   localparam int LV_GEN_BASE      = 21;   // General inputs 1..9
   localparam int LV_OUT_BASE      = 30;   // Outputs alarm,end,homep,lc,move,psts,ready,run
   localparam int PIN_NEG_LIMIT    = 21;   // Negative limit pin

   // Factory levels: only the timing differential input is set
   localparam logic [LV_N-1:0] LV_DEFAULT = 38'h00_0008_0000;

   // Map a system input pin to the setting that governs it
   function automatic int pin_lv(input int p);
      return (p == PIN_NEG_LIMIT) ? LV_OVERTRAVEL : p;
   endfunction

   // ****************************************************************
   // Whole state of the block
   // ****************************************************************
   typedef struct packed {
      logic [N_SYS_PIN-1:0] io_s1;          // I/O connector sync, stage 1
      logic [N_SYS_PIN-1:0] io_s2;          // I/O connector sync, stage 2
      logic [N_SYS_PIN-1:0] drv_s1;         // Driver connector sync, stage 1
      logic [N_SYS_PIN-1:0] drv_s2;         // Driver connector sync, stage 2
      logic [N_GEN-1:0]     gen_s1;         // General input sync, stage 1
      logic [N_GEN-1:0]     gen_s2;         // General input sync, stage 2
      logic [LV_N-1:0]      active;         // Levels in force
      logic [LV_N-1:0]      written;        // Levels as last written
      logic                 loaded;         // Power-up load done
      logic [N_SYS_PIN-1:0] sys_in_active;  // Sensed system inputs
      logic [N_GEN-1:0]     gen_in_status;  // Reported general inputs
      logic [N_OUT-1:0]     io_out_pin;     // I/O connector outputs
      logic [N_OUT-1:0]     drv_out_pin;    // Driver connector outputs
      logic                 lv_rd_val;      // Readback bit
      logic                 save_stb;       // Save strobe to storage
      logic [LV_N-1:0]      save_data;      // Levels handed to storage
   } iolvl_state_t;

endpackage

// file: tb/iolvl_nvm_model.sv
// Nonvolatile storage model that keeps the last saved level record
module iolvl_nvm_model
   import iolvl_pkg::*;
(
   // Clock
   input  wire logic            ref_clk,
   // Save request from the block
   input  wire logic            save_stb,
   input  wire logic [LV_N-1:0] save_data,
   // Stored record shown to the block
   output logic      [LV_N-1:0] level,
   output logic      [LV_N-1:0] valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // Blank part: nothing was ever saved
   initial begin
      level = '0;
      valid = '0;
   end
   // Storage survives reset, so it has no reset input
   always @(posedge ref_clk) begin
      if (save_stb) begin
         level <= save_data;
         valid <= '1;
      end
   end
endmodule

// file: tb/iolvl_core_tb.sv
// Self-checking bench for the active-level block
module iolvl_core_tb
   import iolvl_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic                       ref_clk, rst_b, drv_conn_en, lv_wr_en, lv_wr_val, save_parameters_cmd;
   logic                       lv_rd_val, nvm_save_stb;
   logic [N_SYS_PIN-1:0]       io_in_pin, drv_in_pin, sys_in_active;
   logic [N_GEN-1:0]           general_input, gen_assign_en, gen_in_status, eg;
   logic [N_GEN-1:0][FN_W-1:0] gen_assign_fn;
   logic [IDX_W-1:0]           lv_wr_idx, lv_rd_idx;
   logic [LV_N-1:0]            nvm_level, nvm_valid, nvm_save_data, active_level_setting, lv;
   logic [N_OUT-1:0]           sys_out_assert, io_out_pin, drv_out_pin;
   int                         mismatches, checked;
   iolvl_core u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .io_in_pin(io_in_pin), .drv_in_pin(drv_in_pin),
      .general_input(general_input), .drv_conn_en(drv_conn_en), .gen_assign_en(gen_assign_en),
      .gen_assign_fn(gen_assign_fn), .lv_wr_en(lv_wr_en), .lv_wr_idx(lv_wr_idx), .lv_wr_val(lv_wr_val),
      .lv_rd_idx(lv_rd_idx), .lv_rd_val(lv_rd_val), .save_parameters_cmd(save_parameters_cmd),
      .nvm_level(nvm_level), .nvm_valid(nvm_valid), .nvm_save_stb(nvm_save_stb),
      .nvm_save_data(nvm_save_data), .sys_out_assert(sys_out_assert), .sys_in_active(sys_in_active),
      .gen_in_status(gen_in_status), .io_out_pin(io_out_pin), .drv_out_pin(drv_out_pin),
      .active_level_setting(active_level_setting));
   iolvl_nvm_model u_nvm (.ref_clk(ref_clk), .save_stb(nvm_save_stb), .save_data(nvm_save_data),
      .level(nvm_level), .valid(nvm_valid));
   // ****************************************
   // Helpers
   // ****************************************
   // 50 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Inputs move only at falling edges, away from sampling
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Expected sense: negative limit follows the overtravel level
   function automatic logic [N_SYS_PIN-1:0] e_sys(input logic [N_SYS_PIN-1:0] p);
      return p ^ {lv[12], lv[20:0]};
   endfunction
   // An idle edge after each write keeps the strobe from rising in the step it fell
   task automatic wr(input logic [IDX_W-1:0] idx, input logic v);
      lv_wr_en = 1'b1;
      lv_wr_idx = idx;
      lv_wr_val = v;
      tick(1);
      lv_wr_en = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [IDX_W-1:0] idx, input logic exp);
      lv_rd_idx = idx;
      tick(1);
      chk(lv_rd_val, exp);
   endtask
   // Six cycles low; ends on the load edge so a write may follow at once
   task automatic do_reset();
      rst_b = 1'b0;
      tick(6);
      chk(active_level_setting, LV_DEFAULT);
      rst_b = 1'b1;
      tick(1);
      chk(active_level_setting, lv);
   endtask
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog: the run needs about 1 us
   initial begin
      #100us;
      mismatches++;
      wrap_up();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      // Reset itself is driven only by do_reset, so it is assigned once per step
      {drv_conn_en, lv_wr_en, lv_wr_val, save_parameters_cmd} = '0;
      {io_in_pin, drv_in_pin, general_input, gen_assign_en, gen_assign_fn} = '0;
      {lv_wr_idx, lv_rd_idx, sys_out_assert} = '0;
      lv = LV_DEFAULT;
      do_reset();
      // Factory levels on inputs and outputs
      io_in_pin = 22'h20_1001;
      sys_out_assert = 8'hA5;
      general_input = 9'h003;
      tick(3);
      chk(sys_in_active, e_sys(io_in_pin));
      chk(io_out_pin, sys_out_assert ^ lv[37:30]);
      chk(drv_out_pin, 8'h00);
      chk(gen_in_status, general_input ^ lv[29:21]);
      // Pending writes, one out of range
      wr(6'h00, 1'b1);
      wr(6'h0C, 1'b1);
      wr(6'h09, 1'b1);
      wr(6'h18, 1'b1);
      wr(6'h1F, 1'b1);
      wr(6'h2D, 1'b1);
      rd(6'h00, 1'b1);
      rd(6'h0A, 1'b0);
      rd(6'h18, 1'b1);
      rd(6'h2D, 1'b0);
      chk(active_level_setting, lv);
      chk(sys_in_active, e_sys(io_in_pin));
      // Save hands the written copy to storage for one cycle
      save_parameters_cmd = 1'b1;
      tick(1);
      save_parameters_cmd = 1'b0;
      chk(nvm_save_stb, 1'b1);
      chk(nvm_save_data, LV_DEFAULT | 38'h00_8100_1201);
      tick(1);
      chk(nvm_save_stb, 1'b0);
      chk(active_level_setting, LV_DEFAULT);
      // Saved levels take effect after reset
      lv = LV_DEFAULT | 38'h00_8100_1201;
      do_reset();
      tick(3);
      chk(sys_in_active, e_sys(io_in_pin));
      chk(io_out_pin, sys_out_assert ^ lv[37:30]);
      chk(gen_in_status, general_input ^ lv[29:21]);
      // An unsaved write is lost at reset
      wr(6'h0E, 1'b1);
      do_reset();
      // Driver connector in use, input 1 takes the abort function, input 2 an unknown code
      drv_conn_en = 1'b1;
      drv_in_pin = 22'h00_4000;
      gen_assign_en = 9'h003;
      gen_assign_fn[1] = 5'h1F;
      general_input = 9'h101;
      tick(3);
      chk(sys_in_active, e_sys(io_in_pin) | e_sys(drv_in_pin));
      chk(drv_out_pin, sys_out_assert ^ lv[37:30]);
      eg = general_input ^ lv[29:21];
      eg[0] = general_input[0] ^ lv[0];
      chk(gen_in_status, eg);
      wrap_up();
   end
endmodule
